// >>> hw/mtc_pkg.sv
// Package with addresses, field positions, opcodes and states of the line-code block
package mtc_pkg;

   // Register page and addresses
   localparam logic [7:0] PAGE_CODEC     = 8'h02;
   localparam logic [7:0] ADDR_DATA_LOW  = 8'hC2;
   localparam logic [7:0] ADDR_DATA_MID  = 8'hC3;
   localparam logic [7:0] ADDR_DATA_HIGH = 8'hC4;
   localparam logic [7:0] ADDR_CONTROL   = 8'hC5;

   // Control register field positions
   localparam int BIT_READY  = 7;
   localparam int BIT_ERROR  = 6;
   localparam int BIT_ENCODE = 5;
   localparam int BIT_DECODE = 4;
   localparam int BIT_DMA    = 2;
   localparam int BIT_ENDIAN = 1;
   localparam int BIT_MODE   = 0;

   // Reset values
   localparam logic [7:0] RST_CONTROL = 8'h00;
   localparam logic [7:0] RST_DATA    = 8'h00;

   // Output byte written on an invalid Manchester pair
   localparam logic [7:0] MAN_BAD_BYTE = 8'hFF;

   // Operation codes software writes to the control register
   localparam logic [7:0] OP_MAN_DECODE     = 8'h10;
   localparam logic [7:0] OP_TOS_DECODE     = 8'h11;
   localparam logic [7:0] OP_MAN_ENCODE     = 8'h20;
   localparam logic [7:0] OP_TOS_ENCODE     = 8'h21;
   localparam logic [7:0] OP_DMA_MAN_DECODE = 8'h16;
   localparam logic [7:0] OP_DMA_TOS_DECODE = 8'h17;
   localparam logic [7:0] OP_DMA_MAN_ENCODE = 8'h26;
   localparam logic [7:0] OP_DMA_TOS_ENCODE = 8'h27;

   // Sequencer states
   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_FETCH = 4'h2,
      ST_CALC  = 4'h4,
      ST_SEND  = 4'h8
   } mtc_state_t;

endpackage

// >>> hw/mtc_codec.sv
// Manchester and three-out-of-six byte codec with register and DMA byte ports
`timescale 1ns/1ps

// Behaviour
// - Three-of-six decode takes high, middle, low data then decode start.
// - Ready flag sets when a three-of-six decode completes.
// - Error flag sets if any six-bit symbol is not a valid code.
// - Valid symbols decode to nibbles per the fixed sixteen-entry table.
// - Encode followed by decode returns the original one or two bytes.
// - Register opcodes 0x10, 0x11, 0x20, 0x21 select the four operations.
// - Block can request an interrupt on a decode error.
// - DMA decode keeps going after an error until transfer ends.
// - Error flag stays set until software writes zero to it.
// - DMA opcodes 0x16, 0x17, 0x26, 0x27 also set DMA and byte order.
// - Encode start launches an encode, decode start launches a decode.
// - Mode bit 0 selects Manchester, 1 selects three-of-six.
// - Registers sit on page 0x2, control at 0xC5, byte access only.
// - Start bits self-clear when the operation begins; ready stays set.
// - Manchester encode: 1 to 01, 0 to 10, upper nibble to middle.
// - Invalid Manchester input sets error and outputs all ones.
// - Three-of-six encode: middle, low in; high, middle, low out.
module mtc_codec (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Special function register port
   input  wire logic [7:0] sfr_page_i,
   input  wire logic [7:0] sfr_addr_i,
   input  wire logic       sfr_wr_i,
   input  wire logic [7:0] sfr_wdata_i,
   output logic      [7:0] sfr_rdata_o,
   // DMA input byte stream
   output logic            dma_in_req_o,
   input  wire logic       dma_in_valid_i,
   input  wire logic [7:0] dma_in_data_i,
   // DMA output byte stream
   output logic            dma_out_req_o,
   output logic      [7:0] dma_out_data_o,
   input  wire logic       dma_out_ack_i,
   // Decode error interrupt request
   output logic            err_irq_o
);

   // Manchester nibble to byte, MSB first
   function automatic logic [7:0] man_encode(input logic [3:0] n);
      logic [7:0] b;
      b = 8'h00;
      for (int i = 0; i < 4; i++) begin
         b[2*i +: 2] = n[i] ? 2'h1 : 2'h2;
      end
      return b;
   endfunction

   // Manchester byte to {error, nibble}
   function automatic logic [4:0] man_decode(input logic [7:0] b);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 0; i < 4; i++) begin
         r[i] = (b[2*i +: 2] == 2'h1);
         if (b[2*i +: 2] == 2'h0 || b[2*i +: 2] == 2'h3) begin
            r[4] = 1'b1;
         end
      end
      return r;
   endfunction
   // Three-of-six symbol of each nibble; one table serves both directions
   localparam logic [5:0] TOS_SYM [16] = '{6'h16, 6'h0D, 6'h0E, 6'h0B, 6'h1C, 6'h19, 6'h1A, 6'h13,
                                           6'h2C, 6'h25, 6'h26, 6'h23, 6'h34, 6'h31, 6'h32, 6'h29};
   // Three-of-six nibble to symbol
   function automatic logic [5:0] tos_encode(input logic [3:0] n);
      return TOS_SYM[n];
   endfunction
   // Symbol to {error, nibble}; inverse search keeps one table for both ways
   function automatic logic [4:0] tos_decode(input logic [5:0] s);
      logic [4:0] r;
      r = 5'h10;
      for (int i = 0; i < 16; i++) begin
         if (tos_encode(4'(i)) == s) begin
            r = {1'b0, 4'(i)};
         end
      end
      return r;
   endfunction
   // Register slot for byte k of n: 0 low, 1 middle, 2 high
   function automatic logic [1:0] byte_slot(input logic [1:0] k, input logic [1:0] n, input logic big);
      return big ? 2'(n - 2'h1 - k) : k;
   endfunction
   // State and registers
   mtc_pkg::mtc_state_t state_r, state_nxt;
   logic [7:0] data_r   [3];
   logic [7:0] data_nxt [3];
   logic       ready_r, ready_nxt;
   logic       err_r, err_nxt;
   logic       encode_r, encode_nxt;
   logic       decode_r, decode_nxt;
   logic       dma_r, dma_nxt;
   logic       endian_r, endian_nxt;
   logic       mode_r, mode_nxt;
   logic       op_encode_r, op_encode_nxt;
   logic       op_tos_r, op_tos_nxt;
   logic [1:0] cnt_r, cnt_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic       in_req_r, in_req_nxt;
   logic       out_req_r, out_req_nxt;
   logic [7:0] out_data_r, out_data_nxt;
   // Decoded write strobes, only on the codec page
   logic       wr_ctl, wr_low, wr_mid, wr_high;
   logic [1:0] n_in, n_out;
   logic [4:0] md_hi, md_lo;
   logic [4:0] td [4];
   logic       tos_bad;
   always_comb begin
      wr_ctl  = sfr_wr_i && sfr_page_i == mtc_pkg::PAGE_CODEC && sfr_addr_i == mtc_pkg::ADDR_CONTROL;
      wr_low  = sfr_wr_i && sfr_page_i == mtc_pkg::PAGE_CODEC && sfr_addr_i == mtc_pkg::ADDR_DATA_LOW;
      wr_mid  = sfr_wr_i && sfr_page_i == mtc_pkg::PAGE_CODEC && sfr_addr_i == mtc_pkg::ADDR_DATA_MID;
      wr_high = sfr_wr_i && sfr_page_i == mtc_pkg::PAGE_CODEC && sfr_addr_i == mtc_pkg::ADDR_DATA_HIGH;
   end
   // Byte counts per operation, and the decoders on the held data
   always_comb begin
      n_in  = op_encode_r ? (op_tos_r ? 2'h2 : 2'h1) : (op_tos_r ? 2'h3 : 2'h2);
      n_out = op_encode_r ? (op_tos_r ? 2'h3 : 2'h2) : (op_tos_r ? 2'h2 : 2'h1);
      md_hi = man_decode(data_r[1]);
      md_lo = man_decode(data_r[0]);
      td[0] = tos_decode({data_r[2][7:2]});
      td[1] = tos_decode({data_r[2][1:0], data_r[1][7:4]});
      td[2] = tos_decode({data_r[1][3:0], data_r[0][7:6]});
      td[3] = tos_decode({data_r[0][5:0]});
      tos_bad = td[0][4] | td[1][4] | td[2][4] | td[3][4];
   end
   // Sequencer, data and control register next values
   always_comb begin
      logic [23:0] sym;
      sym          = 24'h000000;
      state_nxt    = state_r;
      data_nxt     = data_r;
      cnt_nxt      = cnt_r;
      op_encode_nxt = op_encode_r;
      op_tos_nxt   = op_tos_r;
      encode_nxt   = encode_r;
      decode_nxt   = decode_r;
      dma_nxt      = dma_r;
      endian_nxt   = endian_r;
      mode_nxt     = mode_r;
      // Flags are only lowered by a software write of zero
      ready_nxt    = ready_r;
      err_nxt      = err_r;
      out_data_nxt = out_data_r;
      data_nxt[0]  = wr_low ? sfr_wdata_i : data_r[0];
      data_nxt[1]  = wr_mid ? sfr_wdata_i : data_r[1];
      data_nxt[2]  = wr_high ? sfr_wdata_i : data_r[2];
      if (wr_ctl) begin
         ready_nxt  = ready_r & sfr_wdata_i[mtc_pkg::BIT_READY];
         err_nxt    = err_r & sfr_wdata_i[mtc_pkg::BIT_ERROR];
         encode_nxt = sfr_wdata_i[mtc_pkg::BIT_ENCODE];
         decode_nxt = sfr_wdata_i[mtc_pkg::BIT_DECODE];
         dma_nxt    = sfr_wdata_i[mtc_pkg::BIT_DMA];
         endian_nxt = sfr_wdata_i[mtc_pkg::BIT_ENDIAN];
         mode_nxt   = sfr_wdata_i[mtc_pkg::BIT_MODE];
      end
      case (state_r)
         mtc_pkg::ST_IDLE: begin
            if (encode_r || decode_r) begin
               op_encode_nxt = encode_r;
               op_tos_nxt    = mode_r;
               encode_nxt    = 1'b0;
               decode_nxt    = 1'b0;
               cnt_nxt       = 2'h0;
               state_nxt     = dma_r ? mtc_pkg::ST_FETCH : mtc_pkg::ST_CALC;
            end
         end
         mtc_pkg::ST_FETCH: begin
            if (!dma_r) begin
               state_nxt = mtc_pkg::ST_IDLE;
            end else if (dma_in_valid_i) begin
               data_nxt[byte_slot(cnt_r, n_in, endian_r)] = dma_in_data_i;
               cnt_nxt = cnt_r + 2'h1;
               if (cnt_r == n_in - 2'h1) begin
                  state_nxt = mtc_pkg::ST_CALC;
               end
            end
         end
         mtc_pkg::ST_CALC: begin
            ready_nxt = 1'b1;
            cnt_nxt   = 2'h0;
            case ({op_encode_r, op_tos_r})
               2'b10: begin
                  data_nxt[1] = man_encode(data_r[0][7:4]);
                  data_nxt[0] = man_encode(data_r[0][3:0]);
               end
               2'b11: begin
                  sym = {tos_encode(data_r[1][7:4]), tos_encode(data_r[1][3:0]),
                         tos_encode(data_r[0][7:4]), tos_encode(data_r[0][3:0])};
                  data_nxt[2] = sym[23:16];
                  data_nxt[1] = sym[15:8];
                  data_nxt[0] = sym[7:0];
               end
               2'b00: begin
                  data_nxt[1] = 8'h00;
                  data_nxt[0] = (md_hi[4] | md_lo[4]) ? mtc_pkg::MAN_BAD_BYTE : {md_hi[3:0], md_lo[3:0]};
                  err_nxt     = err_nxt | md_hi[4] | md_lo[4];
               end
               default: begin
                  data_nxt[2] = 8'h00;
                  data_nxt[1] = {td[0][3:0], td[1][3:0]};
                  data_nxt[0] = {td[2][3:0], td[3][3:0]};
                  err_nxt     = err_nxt | tos_bad;
               end
            endcase
            // A DMA run carries on past errors; only software ends it
            if (dma_r) begin
               state_nxt    = mtc_pkg::ST_SEND;
               out_data_nxt = data_nxt[byte_slot(2'h0, n_out, endian_r)];
            end else begin
               state_nxt = mtc_pkg::ST_IDLE;
            end
         end
         mtc_pkg::ST_SEND: begin
            if (!dma_r) begin
               state_nxt = mtc_pkg::ST_IDLE;
            end else if (dma_out_ack_i) begin
               cnt_nxt = cnt_r + 2'h1;
               if (cnt_r == n_out - 2'h1) begin
                  cnt_nxt   = 2'h0;
                  state_nxt = mtc_pkg::ST_FETCH;
               end else begin
                  out_data_nxt = data_r[byte_slot(cnt_r + 2'h1, n_out, endian_r)];
               end
            end
         end
         default: begin
            state_nxt = mtc_pkg::ST_IDLE;
         end
      endcase
   end
   // Read data and stream requests, registered so outputs come from flops
   always_comb begin
      case (sfr_addr_i)
         mtc_pkg::ADDR_DATA_LOW:  rdata_nxt = data_r[0];
         mtc_pkg::ADDR_DATA_MID:  rdata_nxt = data_r[1];
         mtc_pkg::ADDR_DATA_HIGH: rdata_nxt = data_r[2];
         mtc_pkg::ADDR_CONTROL:   rdata_nxt = {ready_r, err_r, encode_r, decode_r, 1'b0, dma_r, endian_r, mode_r};
         default:                 rdata_nxt = 8'h00;
      endcase
      if (sfr_page_i != mtc_pkg::PAGE_CODEC) begin
         rdata_nxt = 8'h00;
      end
      in_req_nxt  = (state_nxt == mtc_pkg::ST_FETCH);
      out_req_nxt = (state_nxt == mtc_pkg::ST_SEND);
   end
   // State registers
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r     <= mtc_pkg::ST_IDLE;
         data_r      <= '{mtc_pkg::RST_DATA, mtc_pkg::RST_DATA, mtc_pkg::RST_DATA};
         {ready_r, err_r, encode_r, decode_r} <= mtc_pkg::RST_CONTROL[7:4];
         {dma_r, endian_r, mode_r} <= mtc_pkg::RST_CONTROL[2:0];
         op_encode_r <= 1'b0;
         op_tos_r    <= 1'b0;
         cnt_r       <= 2'h0;
         rdata_r     <= 8'h00;
         in_req_r    <= 1'b0;
         out_req_r   <= 1'b0;
         out_data_r  <= 8'h00;
      end else begin
         state_r     <= state_nxt;
         data_r      <= data_nxt;
         ready_r     <= ready_nxt;
         err_r       <= err_nxt;
         encode_r    <= encode_nxt;
         decode_r    <= decode_nxt;
         dma_r       <= dma_nxt;
         endian_r    <= endian_nxt;
         mode_r      <= mode_nxt;
         op_encode_r <= op_encode_nxt;
         op_tos_r    <= op_tos_nxt;
         cnt_r       <= cnt_nxt;
         rdata_r     <= rdata_nxt;
         in_req_r    <= in_req_nxt;
         out_req_r   <= out_req_nxt;
         out_data_r  <= out_data_nxt;
      end
   end

   // Outputs; the interrupt request is the sticky error flag itself
   assign sfr_rdata_o    = rdata_r;
   assign dma_in_req_o   = in_req_r;
   assign dma_out_req_o  = out_req_r;
   assign dma_out_data_o = out_data_r;
   assign err_irq_o      = err_r;

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_calc_tos_decode;
      state_r == mtc_pkg::ST_CALC && !op_encode_r && op_tos_r;
   endsequence

   a_ready_on_done: assert property (state_r == mtc_pkg::ST_CALC |=> ready_r)
      else $error("ready not set after operation");
   a_tos_bad_sym: assert property (s_calc_tos_decode ##0 tos_bad |=> err_r && err_irq_o)
      else $error("invalid symbol did not raise error");
   a_tos_decode_val: assert property (s_calc_tos_decode ##0 !tos_bad |=>
      tos_encode(data_r[0][3:0]) == $past(data_r[0][5:0]) && tos_encode(data_r[1][7:4]) == $past(data_r[2][7:2]))
      else $error("three-of-six decode value wrong");
   a_error_sticky: assert property (err_r && !wr_ctl |=> err_r)
      else $error("error flag dropped without software write");
   a_dma_keeps_going: assert property (state_r == mtc_pkg::ST_CALC && dma_r && !wr_ctl |=>
      state_r == mtc_pkg::ST_SEND ##0 dma_out_req_o)
      else $error("DMA run did not continue to output");
   a_start_clears: assert property (state_r == mtc_pkg::ST_IDLE && (encode_r || decode_r) && !wr_ctl |=>
      !encode_r && !decode_r && state_r != mtc_pkg::ST_IDLE)
      else $error("start bit did not launch and self-clear");
   a_man_bad_ones: assert property (state_r == mtc_pkg::ST_CALC && !op_encode_r && !op_tos_r &&
      (md_hi[4] || md_lo[4]) |=> data_r[0] == mtc_pkg::MAN_BAD_BYTE && err_r)
      else $error("bad Manchester input not flagged");
   a_man_encode_val: assert property (state_r == mtc_pkg::ST_CALC && op_encode_r && !op_tos_r |=>
      data_r[1] == man_encode($past(data_r[0][7:4])) && data_r[0] == man_encode($past(data_r[0][3:0])))
      else $error("Manchester encode value wrong");
   a_tos_round_trip: assert property (state_r == mtc_pkg::ST_CALC && op_encode_r && op_tos_r |=>
      tos_decode(data_r[2][7:2]) == {1'b0, $past(data_r[1][7:4])} &&
      tos_decode(data_r[0][5:0]) == {1'b0, $past(data_r[0][3:0])})
      else $error("three-of-six encode not reversible");
   a_other_page: assert property (sfr_wr_i && sfr_page_i != mtc_pkg::PAGE_CODEC && state_r == mtc_pkg::ST_IDLE
      && !encode_r && !decode_r |=> $stable(data_r[0]) && $stable(mode_r))
      else $error("write on foreign page changed codec");

endmodule

// >>> verif/mtc_dma_model.sv
// Behavioural DMA partner that feeds and drains the codec byte streams
`timescale 1ns/1ps
module mtc_dma_model (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Memory-to-codec channel
   input  wire logic       in_req_i,
   output logic            in_valid_o,
   output logic      [7:0] in_data_o,
   // Codec-to-memory channel
   input  wire logic       out_req_i,
   input  wire logic [7:0] out_data_i,
   output logic            out_ack_o
);
   logic [7:0] in_q [$];
   logic [7:0] out_q [$];
   int         gap    = 0;  // Idle cycles between transfers, models a busy bus
   int         wait_n = 0;
   logic       v;
   logic       a;
   logic [7:0] d;
   // One transfer at a time; idle data toggles so a stale byte never looks fresh
   initial begin
      in_valid_o = 1'b0;
      in_data_o  = 8'h00;
      out_ack_o  = 1'b0;
      forever begin
         @(posedge clk_i);
         v = 1'b0;
         a = 1'b0;
         d = ~in_data_o;
         if (!rst_i && wait_n >= gap) begin
            if (in_req_i && !in_valid_o && in_q.size() > 0) begin
               v = 1'b1;
               d = in_q.pop_front();
            end else if (out_req_i && !out_ack_o) begin
               a = 1'b1;
               out_q.push_back(out_data_i);
            end
         end
         wait_n = (v || a) ? 0 : wait_n + 1;
         in_valid_o <= v;
         in_data_o  <= d;
         out_ack_o  <= a;
      end
   end
endmodule

// >>> verif/tb.sv
// Self-checking bench for the line-code block: register operations and DMA streams
`timescale 1ns/1ps
module tb;
   logic        clk_i;
   logic        rst_i;
   logic [7:0]  sfr_page_i;
   logic [7:0]  sfr_addr_i;
   logic        sfr_wr_i;
   logic [7:0]  sfr_wdata_i;
   logic [7:0]  sfr_rdata_o;
   logic        dma_in_req_o;
   logic        dma_in_valid_i;
   logic [7:0]  dma_in_data_i;
   logic        dma_out_req_o;
   logic [7:0]  dma_out_data_o;
   logic        dma_out_ack_i;
   logic        err_irq_o;
   int          n_mismatch = 0;
   int          n_compared = 0;
   int          cyc        = 0;
   logic [15:0] w;
   logic [23:0] s;
   logic [7:0]  mb [4] = '{8'h00, 8'hFF, 8'h5A, 8'h93};
   // Nibble to symbol table, kept here so expectations never lean on the design
   localparam logic [5:0] SYM [16] = '{6'h16, 6'h0D, 6'h0E, 6'h0B, 6'h1C, 6'h19, 6'h1A, 6'h13,
                                       6'h2C, 6'h25, 6'h26, 6'h23, 6'h34, 6'h31, 6'h32, 6'h29};

   mtc_codec DUT (.clk_i(clk_i), .rst_i(rst_i), .sfr_page_i(sfr_page_i), .sfr_addr_i(sfr_addr_i),
      .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
      .dma_in_req_o(dma_in_req_o), .dma_in_valid_i(dma_in_valid_i), .dma_in_data_i(dma_in_data_i),
      .dma_out_req_o(dma_out_req_o), .dma_out_data_o(dma_out_data_o), .dma_out_ack_i(dma_out_ack_i),
      .err_irq_o(err_irq_o));

   mtc_dma_model DMA (.clk_i(clk_i), .rst_i(rst_i), .in_req_i(dma_in_req_o), .in_valid_o(dma_in_valid_i),
      .in_data_o(dma_in_data_i), .out_req_i(dma_out_req_o), .out_data_i(dma_out_data_o),
      .out_ack_o(dma_out_ack_i));

   // Expected Manchester byte of one nibble, MSB first
   function automatic logic [7:0] man(input logic [3:0] n);
      for (int i = 0; i < 4; i++) man[2*i +: 2] = n[i] ? 2'b01 : 2'b10;
   endfunction
   // Expected 24-bit symbol string of two bytes, top nibble first
   function automatic logic [23:0] tos(input logic [15:0] x);
      tos = {SYM[x[15:12]], SYM[x[11:8]], SYM[x[7:4]], SYM[x[3:0]]};
   endfunction

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Register write: strobe held one cycle with page, address and data
   task automatic wr(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      sfr_page_i  <= pg;
      sfr_addr_i  <= a;
      sfr_wdata_i <= d;
      sfr_wr_i    <= 1'b1;
      @(posedge clk_i);
      sfr_wr_i    <= 1'b0;
   endtask
   task automatic wctl(input logic [7:0] d);
      wr(mtc_pkg::PAGE_CODEC, mtc_pkg::ADDR_CONTROL, d);
   endtask
   // Read data is registered, so it is taken one edge after the address
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      sfr_page_i <= mtc_pkg::PAGE_CODEC;
      sfr_addr_i <= a;
      @(posedge clk_i);
      #1;
      d = sfr_rdata_o;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      chk(d, e);
   endtask
   task automatic regs(input logic [7:0] h, input logic [7:0] m, input logic [7:0] l);
      rchk(mtc_pkg::ADDR_DATA_HIGH, h);
      rchk(mtc_pkg::ADDR_DATA_MID, m);
      rchk(mtc_pkg::ADDR_DATA_LOW, l);
   endtask
   // Register operation; an opcode with the error bit set keeps the flag, so no clear first
   task automatic op(input logic [7:0] c, input logic [23:0] d, input logic [7:0] e);
      logic [7:0] r;
      if (!c[6]) wctl(8'h00);
      wr(mtc_pkg::PAGE_CODEC, mtc_pkg::ADDR_DATA_HIGH, d[23:16]);
      wr(mtc_pkg::PAGE_CODEC, mtc_pkg::ADDR_DATA_MID, d[15:8]);
      wr(mtc_pkg::PAGE_CODEC, mtc_pkg::ADDR_DATA_LOW, d[7:0]);
      wctl(c);
      r = 8'h00;
      for (int i = 0; i < 20 && !r[7]; i++) rd(mtc_pkg::ADDR_CONTROL, r);
      chk(r, e);
   endtask
   // DMA operation; a fresh one aborts the previous stream before bytes are queued
   task automatic dma(input logic f, input logic [7:0] c, input logic [23:0] din, input int nin,
                      input logic [23:0] dout, input int nout);
      if (f) wctl(8'h00);
      repeat (2) @(posedge clk_i);
      DMA.out_q.delete();
      for (int i = nin - 1; i >= 0; i--) DMA.in_q.push_back(din[8*i +: 8]);
      if (f) wctl(c);
      for (int i = 0; i < 400 && DMA.out_q.size() < nout; i++) @(posedge clk_i);
      chk(8'(DMA.out_q.size()), 8'(nout));
      for (int i = 0; i < nout; i++) chk(DMA.out_q[i], dout[8*(nout-1-i) +: 8]);
   endtask
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Clock at 10 MHz
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   // Hang guard, well above the several hundred cycles the tests need
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 30000) begin
         n_mismatch++;
         finish_test();
      end
   end

   initial begin
      rst_i       = 1'b1;
      sfr_page_i  = 8'h00;
      sfr_addr_i  = 8'h00;
      sfr_wr_i    = 1'b0;
      sfr_wdata_i = 8'h00;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      // Reset values, foreign page write and unmapped address
      rchk(mtc_pkg::ADDR_CONTROL, mtc_pkg::RST_CONTROL);
      regs(mtc_pkg::RST_DATA, mtc_pkg::RST_DATA, mtc_pkg::RST_DATA);
      chk({7'h00, err_irq_o}, 8'h00);
      wr(8'h00, mtc_pkg::ADDR_DATA_LOW, 8'h77);
      rchk(mtc_pkg::ADDR_DATA_LOW, 8'h00);
      rchk(8'hC6, 8'h00);
      $display("Test registers done");
      // Three-of-six round trips; four words cover all sixteen symbols
      for (int i = 0; i < 4; i++) begin
         w = 16'(16'h0123 + 16'h4444 * i);
         s = tos(w);
         op(mtc_pkg::OP_TOS_ENCODE, {8'h00, w}, 8'h81);
         regs(s[23:16], s[15:8], s[7:0]);
         op(mtc_pkg::OP_TOS_DECODE, s, 8'h81);
         regs(8'h00, w[15:8], w[7:0]);
      end
      $display("Test three-of-six done");
      // Manchester round trips, edge bytes included
      for (int i = 0; i < 4; i++) begin
         op(mtc_pkg::OP_MAN_ENCODE, {16'h0000, mb[i]}, 8'h80);
         regs(8'h00, man(mb[i][7:4]), man(mb[i][3:0]));
         op(mtc_pkg::OP_MAN_DECODE, {8'h00, man(mb[i][7:4]), man(mb[i][3:0])}, 8'h80);
         regs(8'h00, 8'h00, mb[i]);
      end
      $display("Test Manchester done");
      // Bad input, flag held through a later good operation, then cleared by software
      op(mtc_pkg::OP_MAN_DECODE, 24'h0000AA, 8'hC0);
      regs(8'h00, 8'h00, mtc_pkg::MAN_BAD_BYTE);
      chk({7'h00, err_irq_o}, 8'h01);
      op(8'h50, 24'h0096A9, 8'hC0);
      regs(8'h00, 8'h00, 8'h61);
      s = tos(16'h1234) & 24'hFFFFC0;
      op(mtc_pkg::OP_TOS_DECODE, s, 8'hC1);
      regs(8'h00, 8'h12, 8'h30);
      wctl(8'h00);
      rchk(mtc_pkg::ADDR_CONTROL, 8'h00);
      chk({7'h00, err_irq_o}, 8'h00);
      $display("Test errors done");
      // DMA: bad then good decode in one stream, then every DMA opcode
      s = tos(16'hA5C3) & 24'h03FFFF;
      dma(1'b1, mtc_pkg::OP_DMA_TOS_DECODE, s, 3, 24'h0005C3, 2);
      rchk(mtc_pkg::ADDR_CONTROL, 8'hC7);
      dma(1'b0, 8'h00, tos(16'h3C5A), 3, 24'h003C5A, 2);
      rchk(mtc_pkg::ADDR_CONTROL, 8'hC7);
      chk({7'h00, err_irq_o}, 8'h01);
      dma(1'b1, mtc_pkg::OP_DMA_TOS_ENCODE, 24'h007E81, 2, tos(16'h7E81), 3);
      rchk(mtc_pkg::ADDR_CONTROL, 8'h87);
      // Little-endian stream: low register goes first both ways
      s = tos(16'h7E81);
      dma(1'b1, 8'h25, 24'h00817E, 2, {s[7:0], s[15:8], s[23:16]}, 3);
      rchk(mtc_pkg::ADDR_CONTROL, 8'h85);
      DMA.gap = 3;
      dma(1'b1, mtc_pkg::OP_DMA_MAN_ENCODE, 24'h0000C4, 1, {8'h00, man(4'hC), man(4'h4)}, 2);
      rchk(mtc_pkg::ADDR_CONTROL, 8'h86);
      dma(1'b1, mtc_pkg::OP_DMA_MAN_DECODE, 24'h005A9A, 2, 24'h0000C4, 1);
      rchk(mtc_pkg::ADDR_CONTROL, 8'h86);
      wctl(8'h00);
      $display("Test DMA done");
      finish_test();
   end
endmodule
